// >>> rtl/crq_top.sv
// Receive slot status, slot locking and enhanced receive queue with AHB-Lite registers
//
// Functional notes
// - Frame sets full; second unread frame sets overrun
// - Queue reads during reception clear low overrun
// - Slot 5/15 locked past frame: queue drops
// - Slot 5 (even write pointer) or 15 (odd) word write in window loses frame
// - No timestamp: window EOF bit 7 to IFS 2
// - Timestamp on: window EOF bit 5 to 7
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module crq_top
  import crq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Receive path from the protocol engine
  input wire logic rx_active,
  input wire logic rx_to_queue,
  input wire logic [3:0] rx_pos,
  input wire logic rx_done,
  input wire logic [3:0] rx_slot,
  input wire logic [31:0] rx_word,
  // Interrupt
  output logic irq
);
  crq_mem_if mif ();
  crq_mem u_mem (.core_clk(core_clk), .m(mif));

  crq_bus_state_t state_reg;
  logic [7:0] addr_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [SLOTS-1:0] full_reg, ovr_reg, armed_reg;
  logic [QPTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [3:0] qcnt_reg;
  logic lock_reg;
  logic [3:0] lock_slot_reg;
  logic [LOCK_CNT_W-1:0] lock_cnt_reg;
  logic drop_reg, lose_reg;
  logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
  logic irq_reg;

  // Slot word decode, shared by read and write sides
  function automatic logic is_slot(input logic [7:0] a);
    return a[7:6] == SLOT_BASE_OFS[7:6];
  endfunction

  // Loss window by timestamp selection
  function automatic logic in_window(input logic [1:0] ts, input logic [3:0] pos);
    if (ts == TS_OFF) begin
      return (pos >= POS_EOF7) && (pos <= POS_IFS2);
    end
    return (pos >= POS_EOF5) && (pos <= POS_EOF7);
  endfunction

  logic addr_ok, wr_ev, rd_ev, cs_wr, cs_rd, pop, unlock;
  logic qen, frz, slot_rx, queue_rx, q_push, q_ovf, lock_hot;
  logic [3:0] sel_slot, exp_slot;

  // Bus events, all taken in the data phase
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_ev = (state_reg == CRQ_WR);
  assign rd_ev = (state_reg == CRQ_RD) && !hready_reg;
  assign sel_slot = addr_reg[5:2];
  assign cs_wr = wr_ev && is_slot(addr_reg);
  assign cs_rd = rd_ev && is_slot(addr_reg);
  assign pop = rd_ev && (addr_reg == QDATA_OFS) && (qcnt_reg != 4'h0);
  assign unlock = rd_ev && (addr_reg == UNLOCK_OFS);

  // Receive side decisions
  assign qen = ctrl_reg[CTRL_QEN_BIT];
  assign frz = ctrl_reg[CTRL_FRZ_BIT];
  assign slot_rx = rx_done && !frz && !rx_to_queue && armed_reg[rx_slot]
                   && !(lock_reg && lock_slot_reg == rx_slot);
  assign queue_rx = rx_done && !frz && rx_to_queue && qen;
  assign q_push = queue_rx && !drop_reg && !lose_reg && (qcnt_reg != QCNT_FULL);
  assign q_ovf = queue_rx && !drop_reg && !lose_reg && (qcnt_reg == QCNT_FULL);
  assign exp_slot = wr_ptr_reg[0] ? SLOT_B : SLOT_A;
  assign lock_hot = lock_reg && qen && armed_reg[lock_slot_reg]
                    && (lock_slot_reg == SLOT_A || lock_slot_reg == SLOT_B);

  // Storage hookup; read data tracks the queue head
  assign mif.wr_en = q_push;
  assign mif.wr_addr = wr_ptr_reg;
  assign mif.wr_data = rx_word;
  assign mif.rd_addr = rd_ptr_reg;

  // Bus phase tracking; reads take one wait state for registered data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CRQ_IDLE;
      addr_reg <= 8'h00;
      hready_reg <= 1'b1;
    end else begin
      hready_reg <= 1'b1;
      if (rd_ev) begin
        state_reg <= CRQ_RD;
      end else if (addr_ok) begin
        state_reg <= hwrite ? CRQ_WR : CRQ_RD;
        addr_reg <= haddr[7:0];
        hready_reg <= hwrite;
      end else begin
        state_reg <= CRQ_IDLE;
      end
      if (state_reg == CRQ_RD && hready_reg) begin
        state_reg <= addr_ok ? (hwrite ? CRQ_WR : CRQ_RD) : CRQ_IDLE;
      end
    end
  end

  // Read data mux; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_ev) begin
      hrdata_reg <= 32'h0000_0000;
      if (is_slot(addr_reg)) begin
        hrdata_reg <= {29'h0, armed_reg[sel_slot], ovr_reg[sel_slot], full_reg[sel_slot]};
      end else begin
        case (addr_reg)
          CTRL_OFS: hrdata_reg <= {28'h0, ctrl_reg};
          FULL_OFS: hrdata_reg <= {16'h0, full_reg};
          OVR_OFS: hrdata_reg <= {16'h0, ovr_reg};
          QSTAT_OFS: hrdata_reg <= {22'h0, drop_reg, lock_slot_reg, lock_reg, qcnt_reg};
          QDATA_OFS: hrdata_reg <= (qcnt_reg != 4'h0) ? mif.rd_data : 32'h0000_0000;
          IRQ_STAT_OFS: hrdata_reg <= {28'h0, irq_stat_reg};
          IRQ_MASK_OFS: hrdata_reg <= {28'h0, irq_mask_reg};
          default: hrdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RST;
      irq_mask_reg <= '0;
    end else if (wr_ev) begin
      if (addr_reg == CTRL_OFS) begin
        ctrl_reg <= hwdata[CTRL_W-1:0];
      end
      if (addr_reg == IRQ_MASK_OFS) begin
        irq_mask_reg <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // Slot status: frames set full then overrun; writes load armed from bit 0 and clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      full_reg <= '0;
      ovr_reg <= '0;
      armed_reg <= '0;
    end else begin
      if (cs_wr) begin
        armed_reg[sel_slot] <= hwdata[0];
        full_reg[sel_slot] <= 1'b0;
        ovr_reg[sel_slot] <= 1'b0;
      end
      // Unlock consumes the locked message
      if (unlock && lock_reg) begin
        full_reg[lock_slot_reg] <= 1'b0;
        ovr_reg[lock_slot_reg] <= 1'b0;
      end
      // Flaw kept as silicon does: pops mid-reception wipe low overruns
      if (pop && rx_active && qen) begin
        ovr_reg <= ovr_reg & ~LOW_SLOTS_MASK;
      end
      // Set wins over every clear above
      if (slot_rx) begin
        full_reg[rx_slot] <= 1'b1;
        if (full_reg[rx_slot]) begin
          ovr_reg[rx_slot] <= 1'b1;
        end
      end
    end
  end

  // One slot lock at a time; a slot word read moves it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg <= 1'b0;
      lock_slot_reg <= 4'h0;
    end else if (cs_rd) begin
      lock_reg <= 1'b1;
      lock_slot_reg <= sel_slot;
    end else if (unlock) begin
      lock_reg <= 1'b0;
    end
  end

  // Lock age on slots 5 and 15; past one frame time the queue drops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_cnt_reg <= '0;
      drop_reg <= 1'b0;
    end else begin
      if (!lock_hot || cs_rd) begin
        lock_cnt_reg <= '0;
      end else if (lock_cnt_reg != LOCK_CNT_W'(FRAME_CYCLES)) begin
        lock_cnt_reg <= lock_cnt_reg + 1'b1;
      end
      if (lock_hot && !cs_rd && lock_cnt_reg == LOCK_CNT_W'(FRAME_CYCLES - 1)) begin
        drop_reg <= 1'b1;
      end else if (!lock_reg || unlock) begin
        drop_reg <= 1'b0;
      end
    end
  end

  // Badly timed word write to slot 5 (even write pointer) or 15 (odd) marks the queue frame under reception as lost
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lose_reg <= 1'b0;
    end else if (rx_done) begin
      lose_reg <= 1'b0;
    end else if (cs_wr && sel_slot == exp_slot && qen && !frz && rx_active && rx_to_queue
                 && in_window(ctrl_reg[CTRL_TS_LSB +: 2], rx_pos)) begin
      lose_reg <= 1'b1;
    end
  end

  // Queue pointers; a lost frame leaves no trace at all
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      qcnt_reg <= 4'h0;
    end else begin
      if (q_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      qcnt_reg <= qcnt_reg + {3'h0, q_push} - {3'h0, pop};
    end
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_ev && addr_reg == IRQ_STAT_OFS)
                       ? hwdata[IRQ_W-1:0] : '0))
                      | {queue_rx && drop_reg, q_ovf,
                         slot_rx && full_reg[rx_slot], q_push};
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign hreadyout = hready_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign irq = irq_reg;

  sequence s_lock_expires;
    lock_hot && !cs_rd && lock_cnt_reg == LOCK_CNT_W'(FRAME_CYCLES - 1);
  endsequence

  sequence s_window_write(logic w);
    cs_wr && sel_slot == exp_slot && qen && !frz && rx_active && rx_to_queue
      && !rx_done && w;
  endsequence

  full_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    slot_rx |=> full_reg[$past(rx_slot)])
    else $error("slot not marked full after frame");
  overrun_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    slot_rx && full_reg[rx_slot] |=> ovr_reg[$past(rx_slot)] && irq_stat_reg[IRQ_OVR])
    else $error("second frame did not mark overrun");
  overrun_wipe_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pop && rx_active && qen && !slot_rx |=> (ovr_reg & LOW_SLOTS_MASK) == 16'h0000)
    else $error("queue read did not clear low overruns");
  lock_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_lock_expires |=> drop_reg ##0 (!q_push))
    else $error("expired lock did not start dropping");
  lost_frame_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    lose_reg && queue_rx && !pop |=> qcnt_reg == $past(qcnt_reg) && !irq_stat_reg[IRQ_QOVF]
      || $past(irq_stat_reg[IRQ_QOVF]))
    else $error("frame after window write was stored");
  window_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_window_write(ctrl_reg[CTRL_TS_LSB +: 2] == TS_OFF && rx_pos == POS_IFS2) |=> lose_reg)
    else $error("write at second interframe bit not caught");
  window_on_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_window_write(ctrl_reg[CTRL_TS_LSB +: 2] != TS_OFF && rx_pos == POS_EOF5) |=> lose_reg)
    else $error("write at fifth end bit not caught");
  lock_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    lock_reg && rx_done && !rx_to_queue && rx_slot == lock_slot_reg && !cs_wr && !unlock
      |=> $stable(full_reg[$past(rx_slot)]))
    else $error("locked slot was updated by receive");
endmodule

// >>> rtl/crq_pkg.sv
// Shared constants and types for the receive queue and slot status block
package crq_pkg;
  // Bus and register map (byte addresses, one word each)
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FULL_OFS = 8'h04;
  localparam logic [7:0] OVR_OFS = 8'h08;
  localparam logic [7:0] QSTAT_OFS = 8'h0c;
  localparam logic [7:0] QDATA_OFS = 8'h10;
  localparam logic [7:0] UNLOCK_OFS = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;
  localparam logic [7:0] SLOT_BASE_OFS = 8'h40;
  // Control register fields
  localparam int CTRL_QEN_BIT = 0;
  localparam int CTRL_TS_LSB = 1;
  localparam int CTRL_FRZ_BIT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] TS_OFF = 2'h0;
  // Slots and queue
  localparam int SLOTS = 16;
  localparam int QDEPTH = 8;
  localparam int QPTR_W = 3;
  localparam logic [3:0] QCNT_FULL = 4'h8;
  localparam logic [3:0] SLOT_A = 4'h5;
  localparam logic [3:0] SLOT_B = 4'hf;
  localparam logic [15:0] LOW_SLOTS_MASK = 16'h00ff;
  // Frame position: 1..7 end-of-frame bits, 8..10 interframe bits
  localparam logic [3:0] POS_EOF5 = 4'h5;
  localparam logic [3:0] POS_EOF7 = 4'h7;
  localparam logic [3:0] POS_IFS2 = 4'h9;
  // Lock timeout: one frame time, least time so rounded up
  localparam int FRAME_TIME_NS = 3500;
  localparam int CLK_PERIOD_NS = 25;
  localparam int FRAME_CYCLES = (FRAME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CNT_W = 8;
  // Interrupt status bits
  localparam int IRQ_RXQ = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_QOVF = 2;
  localparam int IRQ_LDROP = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [1:0] {CRQ_IDLE, CRQ_WR, CRQ_RD} crq_bus_state_t;
endpackage

// >>> rtl/crq_mem_if.sv
// Carrier between the queue controller and its storage
`timescale 1ns/10ps
interface crq_mem_if;
  logic wr_en;
  logic [2:0] wr_addr;
  logic [31:0] wr_data;
  logic [2:0] rd_addr;
  logic [31:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> rtl/crq_mem.sv
// Queue storage with registered read data
`timescale 1ns/10ps
module crq_mem
  import crq_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Storage port
  crq_mem_if.mem m
);
  logic [DATA_W-1:0] store [QDEPTH];

  // Write port; no reset so it maps to plain RAM
  always_ff @(posedge core_clk) begin
    if (m.wr_en) begin
      store[m.wr_addr] <= m.wr_data;
    end
  end

  // Read data always registered, lags the address by one edge
  always_ff @(posedge core_clk) begin
    m.rd_data <= store[m.rd_addr];
  end
endmodule

// >>> tb/crq_rx_model.sv
// Protocol engine model that walks each received frame through its end bits
`timescale 1ns/10ps
module crq_rx_model #(
  parameter int BIT_CYC = 8
) (
  // Clock
  input wire logic core_clk,
  // Receive path toward the block
  output logic rx_active,
  output logic rx_to_queue,
  output logic [3:0] rx_pos,
  output logic rx_done,
  output logic [3:0] rx_slot,
  output logic [31:0] rx_word
);
  // Quiet receive path at time zero
  initial begin
    rx_active = 1'b0;
    rx_to_queue = 1'b0;
    rx_pos = 4'h0;
    rx_done = 1'b0;
    rx_slot = 4'h0;
    rx_word = 32'h0;
  end

  // One frame: body, seven end bits, three interframe bits, then the done pulse
  task automatic frame(input logic to_q, input logic [3:0] slot, input logic [31:0] word);
    @(posedge core_clk);
    rx_active <= 1'b1;
    rx_to_queue <= to_q;
    repeat (BIT_CYC) @(posedge core_clk);
    for (int p = 1; p <= 10; p++) begin
      rx_pos <= 4'(p);
      repeat (BIT_CYC) @(posedge core_clk);
    end
    rx_pos <= 4'h0;
    rx_done <= 1'b1;
    rx_slot <= slot;
    rx_word <= word;
    @(posedge core_clk);
    rx_done <= 1'b0;
    rx_active <= 1'b0;
    rx_to_queue <= 1'b0;
    // Stale payload is inverted so it never passes for a fresh frame
    rx_slot <= ~slot;
    rx_word <= ~word;
  endtask
endmodule

// >>> tb/tb.sv
// Testbench: AHB-Lite register tasks and receive path scenarios
`timescale 1ns/10ps
module tb
  import crq_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  wire hreadyout;
  wire [31:0] hrdata;
  wire hresp;
  wire rx_active, rx_to_queue, rx_done, irq;
  wire [3:0] rx_pos, rx_slot;
  wire [31:0] rx_word;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [7:0] rst_ofs [6] = '{CTRL_OFS, FULL_OFS, OVR_OFS, QSTAT_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS};
  int w_ts [10] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 3};
  int w_pos [10] = '{6, 7, 9, 10, 4, 5, 7, 8, 6, 7};
  int w_lost [10] = '{0, 1, 1, 0, 0, 1, 1, 0, 1, 1};

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  crq_top i_dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .rx_active(rx_active),
    .rx_to_queue(rx_to_queue),
    .rx_pos(rx_pos),
    .rx_done(rx_done),
    .rx_slot(rx_slot),
    .rx_word(rx_word),
    .irq(irq)
  );

  crq_rx_model #(.BIT_CYC(8)) i_rx (
    .core_clk(core_clk),
    .rx_active(rx_active),
    .rx_to_queue(rx_to_queue),
    .rx_pos(rx_pos),
    .rx_done(rx_done),
    .rx_slot(rx_slot),
    .rx_word(rx_word)
  );

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One single word transfer; each phase held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask

  task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rd);
    chk(n, e, rd);
  endtask

  task automatic wait_pos(input logic [3:0] p);
    do @(posedge core_clk); while (rx_pos !== p);
  endtask

  // Irq follows status one cycle late, so let two edges land first
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // Reset values, then an unmapped place that must stay zero
    foreach (rst_ofs[i]) chk_rd("reset value", rst_ofs[i], 32'h0);
    wr(8'h30, 32'hffffffff);
    chk_rd("unmapped", 8'h30, 32'h0);
    chk("response", 32'h0, {31'h0, hresp});
    // Slot status: first frame fills, unread second overruns, then irq path
    wr(SLOT_BASE_OFS + 8'h0c, 32'h1);
    i_rx.frame(1'b0, 4'h3, 32'h11);
    chk_rd("full", FULL_OFS, 32'h8);
    chk_rd("overrun", OVR_OFS, 32'h0);
    i_rx.frame(1'b0, 4'h3, 32'h12);
    chk_rd("overrun", OVR_OFS, 32'h8);
    chk_rd("irq status", IRQ_STAT_OFS, 32'h2);
    chk_irq(1'b0);
    wr(IRQ_MASK_OFS, 32'h2);
    chk_irq(1'b1);
    wr(IRQ_STAT_OFS, 32'h2);
    chk_irq(1'b0);
    // Low slots receive beside the queue on purpose, so the wipe can be seen
    wr(CTRL_OFS, 32'h1);
    i_rx.frame(1'b1, 4'h0, 32'ha1);
    wr(SLOT_BASE_OFS + 8'h08, 32'h1);
    wr(SLOT_BASE_OFS + 8'h28, 32'h1);
    for (int i = 0; i < 4; i++) i_rx.frame(1'b0, (i < 2) ? 4'h2 : 4'ha, 32'h0);
    chk_rd("overrun", OVR_OFS, 32'h40c);
    fork
      i_rx.frame(1'b1, 4'h0, 32'hb2);
      begin
        wait_pos(4'h1);
        chk_rd("queue data", QDATA_OFS, 32'ha1);
      end
    join
    chk_rd("overrun wiped", OVR_OFS, 32'h400);
    chk_rd("queue status", QSTAT_OFS, 32'h1);
    chk_rd("queue data", QDATA_OFS, 32'hb2);
    // Reading slot 5 locks it; held past one frame time the queue drops
    wr(SLOT_BASE_OFS + 8'h14, 32'h1);
    chk_rd("slot word", SLOT_BASE_OFS + 8'h14, 32'h4);
    chk_rd("queue status", QSTAT_OFS, 32'hb0);
    i_rx.frame(1'b0, 4'h5, 32'h0);
    chk_rd("full", FULL_OFS, 32'h40c);
    repeat (FRAME_CYCLES) @(posedge core_clk);
    wr(IRQ_STAT_OFS, 32'hf);
    i_rx.frame(1'b1, 4'h0, 32'hc3);
    chk_rd("queue status", QSTAT_OFS, 32'h2b0);
    chk_rd("irq status", IRQ_STAT_OFS, 32'h8);
    xfer(1'b0, UNLOCK_OFS, 32'h0, rd);
    // Released lock still names slot 5 in the status word
    chk_rd("queue status", QSTAT_OFS, 32'ha0);
    i_rx.frame(1'b1, 4'h0, 32'hd4);
    chk_rd("queue data", QDATA_OFS, 32'hd4);
    // Slot 5 and 15 word writes at each edge of both loss windows
    for (int i = 0; i < 10; i++) begin
      wr(CTRL_OFS, 32'(w_ts[i] * 2 + 1));
      fork
        i_rx.frame(1'b1, 4'h0, 32'(32'he0 + i));
        begin
          wait_pos(4'(w_pos[i]));
          wr(SLOT_BASE_OFS + 8'h14, 32'h0);
          wr(SLOT_BASE_OFS + 8'h3c, 32'h0);
        end
      join
      chk_rd("queue count", QSTAT_OFS, 32'ha0 + 32'(1 - w_lost[i]));
      if (w_lost[i] == 0) chk_rd("queue data", QDATA_OFS, 32'(32'he0 + i));
    end
    // Slot 0 with its armed bit cleared is not filled by a received frame
    wr(SLOT_BASE_OFS, 32'h0);
    i_rx.frame(1'b0, 4'h0, 32'h0);
    chk_rd("full", FULL_OFS, 32'h40c);
    // Slot 15 locked and read out promptly: the queue keeps storing
    wr(SLOT_BASE_OFS + 8'h3c, 32'h1);
    chk_rd("slot word", SLOT_BASE_OFS + 8'h3c, 32'h4);
    chk_rd("queue status", QSTAT_OFS, 32'h1f0);
    xfer(1'b0, UNLOCK_OFS, 32'h0, rd);
    i_rx.frame(1'b1, 4'h0, 32'hf3);
    chk_rd("queue data", QDATA_OFS, 32'hf3);
    // Slot words written while no frame is under way lose nothing
    wr(SLOT_BASE_OFS + 8'h14, 32'h0);
    wr(SLOT_BASE_OFS + 8'h3c, 32'h0);
    i_rx.frame(1'b1, 4'h0, 32'hf4);
    chk_rd("queue data", QDATA_OFS, 32'hf4);
    // Frozen, or with the queue off, queue frames are not kept
    wr(CTRL_OFS, 32'h9);
    i_rx.frame(1'b1, 4'h0, 32'hf5);
    chk_rd("queue status", QSTAT_OFS, 32'h1e0);
    wr(CTRL_OFS, 32'h0);
    i_rx.frame(1'b1, 4'h0, 32'hf6);
    chk_rd("queue status", QSTAT_OFS, 32'h1e0);
    final_report();
  end
endmodule
